// ### rtl/seq_buffer_params.svh
// constants of the dual-port sequential buffer memory
`ifndef SEQ_BUFFER_PARAMS_SVH
`define SEQ_BUFFER_PARAMS_SVH
`define ADDR_W 12
`define DATA_W 16
`define MEM_DEPTH 4096
`define CMD_DATA_W 12
`define CMD_READ_W 13
`define FIFO_DEPTH 16
`define END1_RESET 12'h0FFF
`define START1_RESET 12'h0000
`define START2_RESET 12'h0000
`define END2_RESET 12'h0000
`define PTR_RESET 12'h0000
`define SEL_START1 3'h0
`define SEL_END1 3'h1
`define SEL_START2 3'h2
`define SEL_END2 3'h3
`define SEL_FLOW 3'h4
`define SEL_FLAGS 3'h5
`define FLOW_RESET 12'h0000
`endif

// ### rtl/seq_buffer_pkg.sv
// types shared by the sequential buffer memory files
package seq_buffer_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } stream_state_t;
endpackage : seq_buffer_pkg

// ### rtl/seq_buffer_ram.sv
// dual-port sequential buffer memory: random port, stream port and shared array
//
// Contract
// - read drives each enabled byte lane from the array; disabled lanes float
// - random write stores only byte lanes whose enable is low
// - chip disabled outside command mode: no access, lines float, standby
// - read with output drive high floats data, stays powered
// - both byte enables high: no access, lines float, powered
// - command write stores data lines 0..11 into the command register
// - command read drives command register onto data lines 0..12
// - command accesses with separate byte enables are accepted
// - advanced stream read outputs word, advances pointer, lowers end flag 1 only when it reaches end of buffer 1
// - reaching end of buffer 2 lowers flag 2, flag 1 holds
// - read without advance holds pointer, flags and output word
// - stream output drive high floats lines yet pointer still advances
// - stream write captures sixteen lines at pointer; advances if enabled
// - deselected without advance: nothing happens, lines float
// - deselected with advance: no transfer, pointer and flags still update
// - a stream write ends at the edge sampling write-not-read or enable high
// - stream enable is sampled only on clock edges
// - counter step enable low increments pointer before that cycle's access
`timescale 1ns/1ps
`default_nettype none
`include "seq_buffer_params.svh"
module seq_buffer_ram
  import seq_buffer_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // random port
  input wire logic chip_enable_n,
  input wire logic command_mode_n,
  input wire logic random_write_not_read,
  input wire logic output_drive_n,
  input wire logic low_byte_en_n,
  input wire logic high_byte_en_n,
  input wire logic [`ADDR_W-1:0] random_addr,
  input wire logic [`DATA_W-1:0] random_data_in,
  output logic [`DATA_W-1:0] random_data_out,
  output logic [1:0] random_lane_oe_n,
  output logic random_standby,
  // stream port
  input wire logic stream_port_en_n,
  input wire logic stream_write_not_read,
  input wire logic pointer_advance_n,
  input wire logic stream_output_drive_n,
  input wire logic counter_step_en_n,
  input wire logic [`DATA_W-1:0] stream_data_in,
  output logic [`DATA_W-1:0] stream_data_out,
  output logic stream_data_oe_n,
  output logic buffer1_end_flag_n,
  output logic buffer2_end_flag_n,
  output logic stream_write_ready,
  output logic [`ADDR_W-1:0] stream_pointer
);
  import seq_buffer_pkg::*;

  logic [`DATA_W-1:0] mem [`MEM_DEPTH];

  // command register file
  logic [`CMD_DATA_W-1:0] start1, end1, start2, end2, flow;
  logic [`CMD_DATA_W-1:0] next_start1, next_end1, next_start2, next_end2, next_flow;

  // stream side state
  stream_state_t state, next_state;
  logic [`ADDR_W-1:0] ptr, next_ptr;
  logic flag1_n, next_flag1_n, flag2_n, next_flag2_n;
  logic [`DATA_W-1:0] sdata, next_sdata;
  logic soe_n, next_soe_n;

  // random side outputs
  logic [`DATA_W-1:0] rdata, next_rdata;
  logic [1:0] roe_n, next_roe_n;
  logic rstby, next_rstby;

  // fifo between stream capture and array write
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [`DATA_W+`ADDR_W-1:0] fifo_in_data, fifo_out_data;
  logic ram_write_stream, next_write_ready;

  function automatic logic [`ADDR_W-1:0] step_ptr(input logic [`ADDR_W-1:0] p);
    step_ptr = p + `ADDR_W'(1);
  endfunction : step_ptr

  function automatic logic [`DATA_W-1:0] merge_bytes(input logic [`DATA_W-1:0] old_w,
                                                     input logic [`DATA_W-1:0] new_w,
                                                     input logic lo_n, input logic hi_n);
    merge_bytes = old_w;
    if (!lo_n) begin
      merge_bytes[7:0] = new_w[7:0];
    end
    if (!hi_n) begin
      merge_bytes[15:8] = new_w[15:8];
    end
  endfunction : merge_bytes

  // command registers are twelve bits wide; lane bits above them are dropped
  function automatic logic [`CMD_DATA_W-1:0] cmd_merge(input logic [`CMD_DATA_W-1:0] old_w,
                                                       input logic [`DATA_W-1:0] new_w,
                                                       input logic lo_n, input logic hi_n);
    logic [`DATA_W-1:0] full_w;
    full_w = merge_bytes({4'h0, old_w}, new_w, lo_n, hi_n);
    cmd_merge = full_w[`CMD_DATA_W-1:0];
  endfunction : cmd_merge

  // a lane takes part while its enable is low
  function automatic logic lanes_on(input logic lo_n, input logic hi_n);
    lanes_on = !(lo_n && hi_n);
  endfunction : lanes_on

  // queued words carry their array address above the data lanes
  function automatic logic [`ADDR_W-1:0] queued_addr(input logic [`DATA_W+`ADDR_W-1:0] w);
    queued_addr = w[`DATA_W+`ADDR_W-1:`DATA_W];
  endfunction : queued_addr

  function automatic logic [`DATA_W-1:0] queued_data(input logic [`DATA_W+`ADDR_W-1:0] w);
    queued_data = w[`DATA_W-1:0];
  endfunction : queued_data

  logic rand_sel, cmd_sel, rand_write, cmd_write, cmd_read, rand_read;
  logic stream_active, advance, stream_write, flag_clear;
  logic [`ADDR_W-1:0] access_ptr;

  always_comb begin
    rand_sel = !chip_enable_n && command_mode_n && lanes_on(low_byte_en_n, high_byte_en_n);
    rand_write = rand_sel && !random_write_not_read;
    rand_read = rand_sel && random_write_not_read;
    // command mode owns the port only while the chip enable is high
    cmd_sel = chip_enable_n && !command_mode_n;
    // byte enables need not both be low for command access
    cmd_write = cmd_sel && !random_write_not_read && lanes_on(low_byte_en_n, high_byte_en_n);
    cmd_read = cmd_sel && random_write_not_read;
    flag_clear = cmd_write && random_addr[2:0] == `SEL_FLAGS;
  end

  // random port output path: registered outputs, one cycle behind the inputs
  always_comb begin
    next_rdata = rdata;
    next_roe_n = 2'b11;
    next_rstby = chip_enable_n && command_mode_n;
    if (rand_read && !output_drive_n) begin
      next_rdata = mem[random_addr];
      next_roe_n = {high_byte_en_n, low_byte_en_n};
    end else if (cmd_read && !output_drive_n) begin
      next_rdata = 16'h0000;
      case (random_addr[2:0])
        `SEL_START1: next_rdata[`CMD_DATA_W-1:0] = start1;
        `SEL_END1: next_rdata[`CMD_DATA_W-1:0] = end1;
        `SEL_START2: next_rdata[`CMD_DATA_W-1:0] = start2;
        `SEL_END2: next_rdata[`CMD_DATA_W-1:0] = end2;
        `SEL_FLOW: next_rdata[`CMD_DATA_W-1:0] = flow;
        `SEL_FLAGS: next_rdata[1:0] = {flag2_n, flag1_n};
        default: next_rdata = 16'h0000;
      endcase
      next_rdata[`DATA_W-1:`CMD_READ_W] = 3'h7; // upper lines read high
      next_roe_n = {high_byte_en_n, low_byte_en_n};
    end
  end

  // command register writes, byte-lane wise
  always_comb begin
    next_start1 = start1;
    next_end1 = end1;
    next_start2 = start2;
    next_end2 = end2;
    next_flow = flow;
    if (cmd_write) begin
      case (random_addr[2:0])
        `SEL_START1: next_start1 = cmd_merge(start1, random_data_in,
                                             low_byte_en_n, high_byte_en_n);
        `SEL_END1: next_end1 = cmd_merge(end1, random_data_in,
                                         low_byte_en_n, high_byte_en_n);
        `SEL_START2: next_start2 = cmd_merge(start2, random_data_in,
                                             low_byte_en_n, high_byte_en_n);
        `SEL_END2: next_end2 = cmd_merge(end2, random_data_in,
                                         low_byte_en_n, high_byte_en_n);
        `SEL_FLOW: next_flow = cmd_merge(flow, random_data_in,
                                         low_byte_en_n, high_byte_en_n);
        default: next_flow = flow;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 16'h0000;
      roe_n <= 2'b11;
      rstby <= 1'b1;
    end else begin
      rdata <= next_rdata;
      roe_n <= next_roe_n;
      rstby <= next_rstby;
    end
  end

  // command registers only change on a command write, so they ride through standby
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      start1 <= `START1_RESET;
      end1 <= `END1_RESET;
      start2 <= `START2_RESET;
      end2 <= `END2_RESET;
      flow <= `FLOW_RESET;
    end else begin
      start1 <= next_start1;
      end1 <= next_end1;
      start2 <= next_start2;
      end2 <= next_end2;
      flow <= next_flow;
    end
  end

  // stream port: all controls sampled on mclk edges only
  // the pointer and flags move on advance even while the port is deselected
  always_comb begin
    stream_active = !stream_port_en_n;
    advance = !pointer_advance_n || !counter_step_en_n;
    stream_write = stream_active && !stream_write_not_read;
    // step enable moves the pointer before this cycle's access
    access_ptr = !counter_step_en_n ? step_ptr(ptr) : ptr;
    next_ptr = advance ? step_ptr(ptr) : ptr;
    next_flag1_n = flag1_n;
    next_flag2_n = flag2_n;
    if (advance) begin
      if (access_ptr == end1) begin
        next_flag1_n = 1'b0;
      end
      if (access_ptr == end2) begin
        next_flag2_n = 1'b0;
      end
    end
    // hardware setting a flag wins over a clear in the same cycle
    if (flag_clear) begin
      if (!random_data_in[0] && !(advance && access_ptr == end1)) begin
        next_flag1_n = 1'b1;
      end
      if (!random_data_in[1] && !(advance && access_ptr == end2)) begin
        next_flag2_n = 1'b1;
      end
    end
  end

  // stream read data, output drive and transfer state
  always_comb begin
    next_sdata = sdata;
    next_soe_n = 1'b1;
    next_state = ST_IDLE;
    if (stream_active && stream_write_not_read) begin
      next_state = ST_READ;
      // a held read re-presents the last word instead of fetching the next one
      if (advance) begin
        next_sdata = (ram_write_stream && queued_addr(fifo_out_data) == access_ptr)
                     ? queued_data(fifo_out_data) : mem[access_ptr];
      end
      next_soe_n = stream_output_drive_n;
    end else if (stream_write) begin
      next_state = ST_WRITE;
    end
    case (state)
      ST_IDLE: next_soe_n = next_soe_n;
      ST_READ: next_soe_n = next_soe_n;
      ST_WRITE: next_soe_n = next_soe_n;
      default: next_state = ST_IDLE;
    endcase
  end

  // words are queued with their address so a slow array write drops data only once the fifo is full
  always_comb begin
    fifo_in_valid = stream_write;
    fifo_in_data = {access_ptr, stream_data_in};
    // ready is registered, so it lags the fifo by one cycle; a push into a full fifo is refused
    next_write_ready = fifo_in_ready;
  end

  stream_fifo #(
    .WIDTH(`DATA_W + `ADDR_W),
    .DEPTH(`FIFO_DEPTH)
  ) write_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(ram_write_stream),
    .out_data(fifo_out_data)
  );

  // random writes take the array first; queued stream words wait for a cycle with no random write
  assign ram_write_stream = fifo_out_valid && !rand_write;

  always_ff @(posedge mclk) begin
    if (rand_write) begin
      mem[random_addr] <= merge_bytes(mem[random_addr], random_data_in,
                                      low_byte_en_n, high_byte_en_n);
    end else if (ram_write_stream) begin
      mem[queued_addr(fifo_out_data)] <= queued_data(fifo_out_data);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr <= `PTR_RESET;
      flag1_n <= 1'b1;
      flag2_n <= 1'b1;
      stream_write_ready <= 1'b1;
    end else begin
      ptr <= next_ptr;
      flag1_n <= next_flag1_n;
      flag2_n <= next_flag2_n;
      stream_write_ready <= next_write_ready;
    end
  end

  // read data and drive live apart from the pointer so a held read keeps its word
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      sdata <= 16'h0000;
      soe_n <= 1'b1;
    end else begin
      state <= next_state;
      sdata <= next_sdata;
      soe_n <= next_soe_n;
    end
  end

  assign random_data_out = rdata;
  assign random_lane_oe_n = roe_n;
  assign random_standby = rstby;
  assign stream_data_out = sdata;
  assign stream_data_oe_n = soe_n;
  assign buffer1_end_flag_n = flag1_n;
  assign buffer2_end_flag_n = flag2_n;
  assign stream_pointer = ptr;
endmodule : seq_buffer_ram
`default_nettype wire

// ### rtl/stream_fifo.sv
// small valid/ready fifo in the stream write path
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
endmodule : stream_fifo
`default_nettype wire

// ### test/seq_buffer_ram_sva.sv
// port-level assertions for the sequential buffer memory
`timescale 1ns/1ps
`default_nettype none
module seq_buffer_ram_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // random port
  input wire logic chip_enable_n,
  input wire logic command_mode_n,
  input wire logic random_write_not_read,
  input wire logic output_drive_n,
  input wire logic low_byte_en_n,
  input wire logic high_byte_en_n,
  input wire logic [1:0] random_lane_oe_n,
  input wire logic random_standby,
  // stream port
  input wire logic stream_port_en_n,
  input wire logic stream_write_not_read,
  input wire logic pointer_advance_n,
  input wire logic stream_output_drive_n,
  input wire logic counter_step_en_n,
  input wire logic stream_data_oe_n,
  input wire logic buffer1_end_flag_n,
  input wire logic buffer2_end_flag_n,
  input wire logic [11:0] stream_pointer
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic rd = !chip_enable_n && command_mode_n && random_write_not_read;
  property p_standby; chip_enable_n && command_mode_n |=> random_standby && random_lane_oe_n == 2'b11; endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");
  property p_lanes; rd && !output_drive_n |=> random_lane_oe_n == {$past(high_byte_en_n), $past(low_byte_en_n)};
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane drive wrong on read");
  property p_oe_off; rd && output_drive_n |=> random_lane_oe_n == 2'b11 && !random_standby; endproperty
  a_oe_off: assert property (p_oe_off) else $error("lanes driven with outputs off");
  property p_no_lane; !chip_enable_n && low_byte_en_n && high_byte_en_n |=> random_lane_oe_n == 2'b11 && !random_standby;
  endproperty
  a_no_lane: assert property (p_no_lane) else $error("lanes driven with no byte enabled");
  property p_step; !pointer_advance_n || !counter_step_en_n |=> stream_pointer == $past(stream_pointer) + 12'h001;
  endproperty
  a_step: assert property (p_step) else $error("pointer did not step");
  property p_hold; pointer_advance_n && counter_step_en_n && command_mode_n |=> $stable(stream_pointer)
    && $stable(buffer1_end_flag_n) && $stable(buffer2_end_flag_n); endproperty
  a_hold: assert property (p_hold) else $error("pointer or flags moved");
  property p_soe; !stream_port_en_n && stream_write_not_read |=> stream_data_oe_n == $past(stream_output_drive_n);
  endproperty
  a_soe: assert property (p_soe) else $error("stream drive wrong on read");
  property p_float; stream_port_en_n || !stream_write_not_read |=> stream_data_oe_n; endproperty
  a_float: assert property (p_float) else $error("stream lines driven");
endmodule : seq_buffer_ram_sva
bind seq_buffer_ram seq_buffer_ram_sva chk (.mclk, .sys_rst, .chip_enable_n, .command_mode_n,
  .random_write_not_read, .output_drive_n, .low_byte_en_n, .high_byte_en_n, .random_lane_oe_n, .random_standby,
  .stream_port_en_n, .stream_write_not_read, .pointer_advance_n, .stream_output_drive_n, .counter_step_en_n,
  .stream_data_oe_n, .buffer1_end_flag_n, .buffer2_end_flag_n, .stream_pointer);
`default_nettype wire

// ### test/stream_master.sv
// stream-side master model: turns a requested operation into stream port pins
`timescale 1ns/1ps
`default_nettype none
module stream_master (
  // request: 0 idle, 1 read, 2 write, 3 read with outputs off
  input wire logic [1:0] op,
  input wire logic adv,
  input wire logic step,
  input wire logic [15:0] wdata,
  // stream port pins
  output logic stream_port_en_n,
  output logic stream_write_not_read,
  output logic pointer_advance_n,
  output logic stream_output_drive_n,
  output logic counter_step_en_n,
  output logic [15:0] stream_data_in
);
  always_comb begin
    stream_port_en_n = op == 2'd0;
    stream_write_not_read = op != 2'd2;
    stream_output_drive_n = op != 2'd1;
    pointer_advance_n = !adv;
    counter_step_en_n = !step;
    // undriven lines show the inverted word so a stale value cannot pass
    stream_data_in = op == 2'd2 ? wdata : ~wdata;
  end
endmodule : stream_master
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the sequential buffer memory
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_enable_n, command_mode_n, random_write_not_read, output_drive_n, low_byte_en_n, high_byte_en_n;
  logic random_standby, stream_port_en_n, stream_write_not_read, pointer_advance_n, stream_output_drive_n;
  logic counter_step_en_n, stream_data_oe_n, buffer1_end_flag_n, buffer2_end_flag_n, stream_write_ready, adv, step;
  logic [1:0] random_lane_oe_n, op;
  logic [11:0] random_addr, stream_pointer;
  logic [15:0] random_data_in, random_data_out, stream_data_in, stream_data_out, wdata;
  logic [15:0] ref_mem [4096];
  logic [31:0] seed = 32'hd442_240f;
  int n_mismatch = 0;
  int checks_done = 0;
  seq_buffer_ram uut (.mclk, .sys_rst, .chip_enable_n, .command_mode_n, .random_write_not_read, .output_drive_n,
    .low_byte_en_n, .high_byte_en_n, .random_addr, .random_data_in, .random_data_out, .random_lane_oe_n,
    .random_standby, .stream_port_en_n, .stream_write_not_read, .pointer_advance_n, .stream_output_drive_n,
    .counter_step_en_n, .stream_data_in, .stream_data_out, .stream_data_oe_n, .buffer1_end_flag_n,
    .buffer2_end_flag_n, .stream_write_ready, .stream_pointer);
  stream_master far_end (.op, .adv, .step, .wdata, .stream_port_en_n, .stream_write_not_read, .pointer_advance_n,
    .stream_output_drive_n, .counter_step_en_n, .stream_data_in);
  initial begin
    forever #5 mclk = ~mclk;
  end
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd
  // m is {low lane off, high lane off}
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] m);
    return {m[0] ? o[15:8] : n[15:8], m[1] ? o[7:0] : n[7:0]};
  endfunction : merge
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // pins change at the falling edge; results are looked at on the next falling edge
  task automatic rcyc(input logic [5:0] c, input logic [11:0] a, input logic [15:0] d);
    {chip_enable_n, command_mode_n, random_write_not_read, output_drive_n, low_byte_en_n, high_byte_en_n} = c;
    random_addr = a;
    random_data_in = d;
    @(posedge mclk);
    @(negedge mclk);
  endtask : rcyc
  task automatic st(input logic [1:0] o, input logic a, input logic s, input logic [15:0] d);
    op = o;
    adv = a;
    step = s;
    wdata = d;
  endtask : st
  // random writes keep the fifo from draining while waiting for it to fill
  task automatic wait_ready(input logic lvl);
    int k;
    k = 0;
    while (stream_write_ready !== lvl && k < 40) begin
      rcyc(lvl ? 6'b111111 : 6'b010100, 12'hfff, rnd());
      k++;
    end
    if (stream_write_ready !== lvl) begin
      cmp("write ready", {15'h0, lvl}, {15'h0, stream_write_ready});
      report_and_stop();
    end
  endtask : wait_ready
  task automatic srd(input logic [1:0] o, input logic a, input logic s, input logic [11:0] p, input logic [1:0] f);
    st(o, a, s, 16'h0000);
    rcyc(6'b111111, 12'h000, 16'h0000);
    cmp("pointer", {4'h0, p}, {4'h0, stream_pointer});
    cmp("end flags", {14'h0, f}, {14'h0, buffer2_end_flag_n, buffer1_end_flag_n});
    cmp("stream drive", {15'h0, o != 2'd1}, {15'h0, stream_data_oe_n});
    if (o == 2'd1) cmp("stream word", ref_mem[s ? p : p - 12'h001], stream_data_out);
  endtask : srd
  initial begin
    int i;
    logic [15:0] d;
    logic [11:0] a;
    logic [1:0] m;
    st(2'd0, 1'b0, 1'b0, 16'h0000);
    {chip_enable_n, command_mode_n, random_write_not_read, output_drive_n, low_byte_en_n, high_byte_en_n} = 6'h3f;
    random_addr = 12'h000;
    random_data_in = 16'h0000;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    for (i = 0; i < 32; i++) begin
      d = rnd();
      a = {2'b01, d[9:0]};
      m = i[1:0];
      ref_mem[a] = rnd();
      rcyc(6'b010100, a, ref_mem[a]);
      d = rnd();
      rcyc({4'b0101, m}, a, d);
      ref_mem[a] = merge(ref_mem[a], d, m);
      rcyc({4'b0110, m}, a, 16'h0000);
      cmp("lane drive", {14'h0, m[0], m[1]}, {14'h0, random_lane_oe_n});
      rcyc(6'b011000, a, 16'h0000);
      cmp("read word", ref_mem[a], random_data_out);
    end
    rcyc(6'b011100, a, 16'h0000);
    cmp("outputs off", 16'h0003, {13'h0, random_standby, random_lane_oe_n});
    rcyc(6'b110000, a, ~ref_mem[a]);
    cmp("standby", 16'h0007, {13'h0, random_standby, random_lane_oe_n});
    rcyc(6'b011000, a, 16'h0000);
    cmp("word kept", ref_mem[a], random_data_out);
    rcyc(6'b100100, 12'h001, 16'hf003);
    rcyc(6'b100100, 12'h003, 16'h000d);
    rcyc(6'b101000, 12'h001, 16'h0000);
    cmp("buffer 1 end", 16'he003, random_data_out);
    for (i = 12; i < 18; i++) begin
      ref_mem[i] = rnd();
      rcyc(6'b010100, i[11:0], ref_mem[i]);
    end
    st(2'd2, 1'b0, 1'b0, rnd());
    wait_ready(1'b0);
    st(2'd0, 1'b0, 1'b0, 16'h0000);
    wait_ready(1'b1);
    repeat (20) rcyc(6'b111111, 12'h000, 16'h0000);
    cmp("pointer", 16'h0000, {4'h0, stream_pointer});
    for (i = 0; i < 12; i++) begin
      ref_mem[i] = rnd();
      st(2'd2, 1'b1, 1'b0, ref_mem[i]);
      rcyc(6'b111111, 12'h000, 16'h0000);
    end
    st(2'd0, 1'b0, 1'b0, 16'h0000);
    repeat (20) rcyc(6'b111111, 12'h000, 16'h0000);
    cmp("end flags", 16'h0002, {14'h0, buffer2_end_flag_n, buffer1_end_flag_n});
    for (i = 0; i < 12; i++) begin
      rcyc(6'b011000, i[11:0], 16'h0000);
      cmp("stream word", ref_mem[i], random_data_out);
    end
    rcyc(6'b100100, 12'h005, 16'h0000);
    srd(2'd1, 1'b1, 1'b0, 12'd13, 2'b11);
    srd(2'd1, 1'b1, 1'b0, 12'd14, 2'b01);
    srd(2'd1, 1'b0, 1'b0, 12'd14, 2'b01);
    srd(2'd3, 1'b1, 1'b0, 12'd15, 2'b01);
    srd(2'd0, 1'b1, 1'b0, 12'd16, 2'b01);
    srd(2'd0, 1'b0, 1'b0, 12'd16, 2'b01);
    srd(2'd1, 1'b0, 1'b1, 12'd17, 2'b01);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
